/* verilog/pmtid_regs.sv */
// Command bank for temperature, power telemetry, bus revision and identity codes.
// Assumes an outside framing engine that decodes bus transactions into one command per
// strobe, and an outside storage engine that loads and keeps the writable identity fields.
//
// Functional notes
// - exponent is five bits, bits 15 to 11
// - mantissa is eleven bits, bits 10 to 0
// - temperature command returns degrees Celsius, read-only
// - output power command returns watts, read-only
// - input power command returns watts, read-only
// - bus revision returns fixed byte 11h
// - maker code high byte writable, kept stored
// - model code high byte writable, kept stored
// - revision field bits 11:8 writable, stored
`default_nettype none

module pmtid_regs
    import pmtid_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE_DEFAULT = 8'h5A,
    parameter logic [7:0] MODEL_CODE_DEFAULT = 8'h3C,
    parameter logic [3:0] REV_CODE_DEFAULT   = 4'h1
)
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic [2:0]               sampleValid,
    input  wire pmtid_pkg::pmtid_linear_t sampleTemp,
    input  wire pmtid_pkg::pmtid_linear_t sampleOutPower,
    input  wire pmtid_pkg::pmtid_linear_t sampleInPower,
    input  wire logic                     cmdValid,
    input  wire pmtid_pkg::pmtid_cmd_t    cmdIn,
    output pmtid_pkg::pmtid_rsp_t         rspOut,
    output logic                          rspValid,
    input  wire logic                     nvmLoadValid,
    input  wire pmtid_pkg::pmtid_nvm_t    nvmLoadImage,
    output pmtid_pkg::pmtid_nvm_t         nvmStoreImage,
    output logic                          nvmStoreReq,
    output logic                          revRewritten
);
    import pmtid_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Telemetry holding words.
    pmtid_linear_t samples [TELEM_CHANNELS];
    logic [15:0]   telemWord [TELEM_CHANNELS];

    assign samples[CH_TEMP] = sampleTemp;
    assign samples[CH_POUT] = sampleOutPower;
    assign samples[CH_PIN]  = sampleInPower;

    // One holding register per measured quantity, each loaded by its own strobe.
    genvar ch;
    generate
        for (ch = 0; ch < TELEM_CHANNELS; ch++) begin : g_telem
            pmtid_linear_hold pmtid_linear_hold_inst (
                .sys_clk     (sys_clk),
                .rst         (rst),
                .sampleValid (sampleValid[ch]),
                .sampleIn    (samples[ch]),
                .linearWord  (telemWord[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////
    // Writable identity fields.
    logic [7:0]  makerCodeWritable_ff;
    logic [7:0]  modelCodeWritable_ff;
    logic [3:0]  revCodeWritable_ff;
    logic        revWritten_ff;
    logic        revRewritten_ff;
    pmtid_nvm_t  storeImage_ff;
    logic        storeReq_ff;
    pmtid_rsp_t  rsp_ff;
    logic        rspValid_ff;

    logic        isWrite;
    logic        wrOk;
    logic        wrMaker;
    logic        wrModel;
    logic        wrRev;
    logic        wrAny;
    logic [7:0]  nxt_makerCodeWritable;
    logic [7:0]  nxt_modelCodeWritable;
    logic [3:0]  nxt_revCodeWritable;
    logic [15:0] nxt_rspData;
    logic [1:0]  nxt_rspBytes;
    logic        nxt_rspNack;

    // Full 16-bit identity words as seen by a read.
    function automatic logic [15:0] id_word(input logic [7:0] high, input logic [7:0] low);
        id_word = {high, low};
    endfunction

    function automatic logic [15:0] rev_word(input logic [3:0] field);
        rev_word = {REV_CODE_FIXED_HIGH, field, REV_CODE_FIXED_LOW};
    endfunction

    // Byte that a block write hands to an eight-bit identity field.
    function automatic logic [7:0] write_high(input logic [15:0] data);
        write_high = data[HIGH_MSB:HIGH_LSB];
    endfunction

    // Nibble that a block write hands to the revision field.
    function automatic logic [3:0] write_rev(input logic [15:0] data);
        write_rev = data[REV_FLD_MSB:REV_FLD_LSB];
    endfunction

    // Codes whose writable field a block write may change.
    function automatic logic is_identity(input logic [7:0] code);
        is_identity = (code == CMD_MAKER_ID) | (code == CMD_MODEL_ID)
                    | (code == CMD_MAKER_REV);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // A block write carries two bytes; only the high byte, or its bits 11:8 for the revision field, reaches storage.
    assign isWrite = cmdValid & cmdIn.isWrite;
    assign wrOk    = isWrite & (cmdIn.byteCount == BYTES_TWO) & is_identity(cmdIn.code);
    assign wrMaker = wrOk & (cmdIn.code == CMD_MAKER_ID);
    assign wrModel = wrOk & (cmdIn.code == CMD_MODEL_ID);
    assign wrRev   = wrOk & (cmdIn.code == CMD_MAKER_REV);
    assign wrAny   = wrMaker | wrModel | wrRev;

    // Next field values. A storage load replaces the reset defaults, and a host write in
    // the same cycle wins over the load. The store image is taken from these values so
    // that it matches what a read returns until the next storage load.
    always_comb begin
        nxt_makerCodeWritable = makerCodeWritable_ff;
        if (wrMaker) begin
            nxt_makerCodeWritable = write_high(cmdIn.data);
        end else if (nvmLoadValid) begin
            nxt_makerCodeWritable = nvmLoadImage.makerCodeWritable;
        end
    end

    always_comb begin
        nxt_modelCodeWritable = modelCodeWritable_ff;
        if (wrModel) begin
            nxt_modelCodeWritable = write_high(cmdIn.data);
        end else if (nvmLoadValid) begin
            nxt_modelCodeWritable = nvmLoadImage.modelCodeWritable;
        end
    end

    always_comb begin
        nxt_revCodeWritable = revCodeWritable_ff;
        if (wrRev) begin
            nxt_revCodeWritable = write_rev(cmdIn.data);
        end else if (nvmLoadValid) begin
            nxt_revCodeWritable = nvmLoadImage.revCodeWritable;
        end
    end

    // Identity fields start from the defaults until storage loads them.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            makerCodeWritable_ff <= MAKER_CODE_DEFAULT;
        end else begin
            makerCodeWritable_ff <= nxt_makerCodeWritable;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            modelCodeWritable_ff <= MODEL_CODE_DEFAULT;
        end else begin
            modelCodeWritable_ff <= nxt_modelCodeWritable;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            revCodeWritable_ff <= REV_CODE_DEFAULT;
        end else begin
            revCodeWritable_ff <= nxt_revCodeWritable;
        end
    end

    // Software is expected to set the revision field once; a second write is flagged.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            revWritten_ff <= 1'b0;
        end else if (wrRev) begin
            revWritten_ff <= 1'b1;
        end
    end

    // The flag only observes a repeated write; the write itself is still taken.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            revRewritten_ff <= 1'b0;
        end else if (wrRev & revWritten_ff) begin
            revRewritten_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Every accepted identity write hands the complete image to the storage engine.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            storeReq_ff <= 1'b0;
        end else begin
            storeReq_ff <= wrAny;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            storeImage_ff <= '0;
        end else if (wrAny) begin
            storeImage_ff.makerCodeWritable <= nxt_makerCodeWritable;
            storeImage_ff.modelCodeWritable <= nxt_modelCodeWritable;
            storeImage_ff.revCodeWritable   <= nxt_revCodeWritable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Answer decode. Writes to read-only or unknown codes, and malformed writes, are refused.
    always_comb begin
        nxt_rspData  = 16'h0000;
        nxt_rspBytes = BYTES_TWO;
        nxt_rspNack  = 1'b0;
        case (cmdIn.code)
            CMD_TEMPERATURE: begin
                nxt_rspData = telemWord[CH_TEMP];
                nxt_rspNack = cmdIn.isWrite;
            end
            CMD_OUTPUT_POWER: begin
                nxt_rspData = telemWord[CH_POUT];
                nxt_rspNack = cmdIn.isWrite;
            end
            CMD_INPUT_POWER: begin
                nxt_rspData = telemWord[CH_PIN];
                nxt_rspNack = cmdIn.isWrite;
            end
            CMD_BUS_REV: begin
                nxt_rspData  = {8'h00, BUS_SPEC_REV_BYTE};
                nxt_rspBytes = BYTES_ONE;
                nxt_rspNack  = cmdIn.isWrite;
            end
            CMD_MAKER_ID: begin
                nxt_rspData = id_word(makerCodeWritable_ff, MAKER_CODE_FIXED);
                nxt_rspNack = cmdIn.isWrite & ~wrOk;
            end
            CMD_MODEL_ID: begin
                nxt_rspData = id_word(modelCodeWritable_ff, MODEL_CODE_FIXED);
                nxt_rspNack = cmdIn.isWrite & ~wrOk;
            end
            CMD_MAKER_REV: begin
                nxt_rspData = rev_word(revCodeWritable_ff);
                nxt_rspNack = cmdIn.isWrite & ~wrOk;
            end
            default: begin
                // Unknown codes are refused and carry no data.
                nxt_rspBytes = 2'h0;
                nxt_rspNack  = 1'b1;
            end
        endcase
        // A write is answered with an acknowledge or a refusal only, never with data.
        if (cmdIn.isWrite) begin
            nxt_rspData  = 16'h0000;
            nxt_rspBytes = 2'h0;
        end
    end

    // One answer pulse follows every command, refused or not.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rspValid_ff <= 1'b0;
        end else begin
            rspValid_ff <= cmdValid;
        end
    end

    // The answer word holds until the next command, so a slow reader still sees it.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rsp_ff <= '0;
        end else if (cmdValid) begin
            rsp_ff.data      <= nxt_rspData;
            rsp_ff.byteCount <= nxt_rspBytes;
            rsp_ff.nack      <= nxt_rspNack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Every output comes straight from a flip-flop.
    assign rspOut        = rsp_ff;
    assign rspValid      = rspValid_ff;
    assign nvmStoreImage = storeImage_ff;
    assign nvmStoreReq   = storeReq_ff;
    assign revRewritten  = revRewritten_ff;

endmodule

`default_nettype wire

/* shared/pmtid_pkg.sv */
// Constants, field layouts and carrier types for the telemetry and identity command bank.
// Assumes a single clock domain; the command framing engine sits outside this bank.
`default_nettype none

package pmtid_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] CMD_TEMPERATURE  = 8'h8D;
    localparam logic [7:0] CMD_OUTPUT_POWER = 8'h96;
    localparam logic [7:0] CMD_INPUT_POWER  = 8'h97;
    localparam logic [7:0] CMD_BUS_REV      = 8'h98;
    localparam logic [7:0] CMD_MAKER_ID     = 8'h99;
    localparam logic [7:0] CMD_MODEL_ID     = 8'h9A;
    localparam logic [7:0] CMD_MAKER_REV    = 8'h9B;

    ////////////////////////////////////////////////////////////////////////////////////////
    localparam int EXP_MSB      = 15;
    localparam int EXP_LSB      = 11;
    localparam int MANT_MSB     = 10;
    localparam int MANT_LSB     = 0;
    localparam int EXP_WIDTH    = 5;
    localparam int MANT_WIDTH   = 11;
    localparam int HIGH_MSB     = 15;
    localparam int HIGH_LSB     = 8;
    localparam int REV_FLD_MSB  = 11;
    localparam int REV_FLD_LSB  = 8;
    localparam int REV_HIGH_MSB = 15;
    localparam int REV_HIGH_LSB = 12;

    ////////////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] BUS_SPEC_REV_BYTE   = 8'h11;
    localparam logic [7:0] MAKER_CODE_FIXED    = 8'h01;
    localparam logic [7:0] MODEL_CODE_FIXED    = 8'h01;
    localparam logic [3:0] REV_CODE_FIXED_HIGH = 4'h0;
    localparam logic [7:0] REV_CODE_FIXED_LOW  = 8'h01;

    // Byte counts of the answers and of a legal block write; telemetry channel count and indices.
    localparam logic [1:0] BYTES_ONE = 2'h1;
    localparam logic [1:0] BYTES_TWO = 2'h2;
    localparam int         TELEM_CHANNELS = 3;
    localparam int         CH_TEMP  = 0;
    localparam int         CH_POUT  = 1;
    localparam int         CH_PIN   = 2;

    ////////////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [EXP_WIDTH-1:0]  exponent;
        logic [MANT_WIDTH-1:0] mantissa;
    } pmtid_linear_t;

    typedef struct packed {
        logic [7:0]  code;
        logic        isWrite;
        logic [1:0]  byteCount;
        logic [15:0] data;
    } pmtid_cmd_t;

    typedef struct packed {
        logic [15:0] data;
        logic [1:0]  byteCount;
        logic        nack;
    } pmtid_rsp_t;

    typedef struct packed {
        logic [7:0] makerCodeWritable;
        logic [7:0] modelCodeWritable;
        logic [3:0] revCodeWritable;
    } pmtid_nvm_t;

endpackage

`default_nettype wire

/* verilog/pmtid_linear_hold.sv */
// Holds the latest linear-format reading of one measured quantity.
// Assumes the measurement datapath is on the same clock and strobes each new sample.
`default_nettype none

module pmtid_linear_hold
    import pmtid_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     sampleValid,
    input  wire pmtid_pkg::pmtid_linear_t sampleIn,
    output logic [15:0]                   linearWord
);
    import pmtid_pkg::*;

    logic [15:0] word_ff;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Exponent and mantissa keep their two's complement codes unchanged, so the value read
    // back is exactly mantissa times two to the exponent.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            word_ff <= 16'h0000;
        end else if (sampleValid) begin
            word_ff[EXP_MSB:EXP_LSB]   <= sampleIn.exponent;
            word_ff[MANT_MSB:MANT_LSB] <= sampleIn.mantissa;
        end
    end

    assign linearWord = word_ff;

endmodule

`default_nettype wire

/* testbench/pmtid_regs_sva.sv */
// Concurrent checks on the ports of the command bank.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module pmtid_regs_sva
    import pmtid_pkg::*;
(
    input wire logic                     sys_clk,
    input wire logic                     rst,
    input wire logic [2:0]               sampleValid,
    input wire pmtid_pkg::pmtid_linear_t sampleTemp,
    input wire logic                     cmdValid,
    input wire pmtid_pkg::pmtid_cmd_t    cmdIn,
    input wire pmtid_pkg::pmtid_rsp_t    rspOut,
    input wire logic                     rspValid,
    input wire pmtid_pkg::pmtid_nvm_t    nvmStoreImage,
    input wire logic                     nvmStoreReq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic        rdCmd;
    logic        wrOk;
    logic [15:0] lastData_ff;
    assign rdCmd = cmdValid && !cmdIn.isWrite;
    assign wrOk  = cmdValid && cmdIn.isWrite && cmdIn.byteCount == 2'h2;
    always_ff @(posedge sys_clk) begin
        lastData_ff <= cmdIn.data;
    end
    a_answer_next: assert property (cmdValid |=> rspValid)
        else $error("no answer one cycle after a command");
    a_no_stray_answer: assert property (!cmdValid |=> !rspValid && !nvmStoreReq)
        else $error("answer or store without a command");
    a_bus_rev_fixed: assert property (rdCmd && cmdIn.code == 8'h98
        |=> rspOut == {16'h0011, 2'h1, 1'b0}) else $error("bus revision answer wrong");
    a_maker_low_fixed: assert property (rdCmd && cmdIn.code == 8'h99
        |=> rspOut.data[7:0] == 8'h01) else $error("maker low byte wrong");
    a_model_low_fixed: assert property (rdCmd && cmdIn.code == 8'h9A
        |=> rspOut.data[7:0] == 8'h01) else $error("model low byte wrong");
    a_rev_fixed_bits: assert property (rdCmd && cmdIn.code == 8'h9B
        |=> rspOut.data[15:12] == 4'h0 && rspOut.data[7:0] == 8'h01)
        else $error("revision fixed bits wrong");
    a_telem_no_write: assert property (cmdValid && cmdIn.isWrite
        && cmdIn.code inside {8'h8D, 8'h96, 8'h97, 8'h98} |=> rspOut.nack && !nvmStoreReq)
        else $error("write to a read-only command accepted");
    a_maker_stored: assert property (wrOk && cmdIn.code == 8'h99
        |=> nvmStoreReq && nvmStoreImage.makerCodeWritable == lastData_ff[15:8])
        else $error("maker byte not stored");
    a_rev_stored: assert property (wrOk && cmdIn.code == 8'h9B
        |=> nvmStoreReq && nvmStoreImage.revCodeWritable == lastData_ff[11:8])
        else $error("revision field not stored");
    a_temp_word: assert property (sampleValid[0] ##1 !sampleValid[0] ##1 rdCmd
        && cmdIn.code == 8'h8D |=> rspOut.data == $past(sampleTemp, 3))
        else $error("temperature word wrong");
endmodule
`default_nettype wire

/* testbench/pmtid_host_model.sv */
// Host model: issues one command at a time and collects the answer.
// Assumes the bank answers on the cycle after the command edge.
`default_nettype none
module pmtid_host_model
    import pmtid_pkg::*;
(
    input  wire logic                  sys_clk,
    output pmtid_pkg::pmtid_cmd_t      cmdIn,
    output logic                       cmdValid,
    input  wire logic                  rspValid,
    input  wire pmtid_pkg::pmtid_rsp_t rspOut
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cmdValid = 1'b0;
        cmdIn    = '0;
    end
    // Block writes carry the high byte in bits 15:8 and a count of two.
    task automatic send(input pmtid_cmd_t c, output pmtid_rsp_t r, output bit late);
        late = 1'b1;
        r    = '0;
        @(posedge sys_clk);
        #1;
        cmdValid = 1'b1;
        cmdIn    = c;
        @(posedge sys_clk);
        #1;
        cmdValid = 1'b0;
        cmdIn    = ~c;
        for (int n = 0; n < 4 && late; n++) begin
            if (rspValid === 1'b1) begin
                late = 1'b0;
                r    = rspOut;
            end else begin
                @(posedge sys_clk);
                #1;
            end
        end
    endtask
endmodule
`default_nettype wire

/* testbench/pmbus_telemetry_id_regs_bench.sv */
// Self-checking bench for the telemetry and identity command bank.
// Assumes the host model and checker are compiled before this file.
`default_nettype none
module pmbus_telemetry_id_regs_bench;
    import pmtid_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        pmtid_cmd_t c;
        pmtid_rsp_t e;
    } pmtid_row_t;
    logic          sys_clk;
    logic          rst;
    logic [2:0]    sampleValid;
    pmtid_linear_t sampleTemp;
    pmtid_linear_t sampleOutPower;
    pmtid_linear_t sampleInPower;
    logic          cmdValid;
    pmtid_cmd_t    cmdIn;
    pmtid_rsp_t    rspOut;
    pmtid_rsp_t    r;
    logic          rspValid;
    logic          nvmLoadValid;
    pmtid_nvm_t    nvmLoadImage;
    pmtid_nvm_t    nvmStoreImage;
    logic          nvmStoreReq;
    logic          revRewritten;
    int            badCount;
    int            nChecks;
    bit            late;
    pmtid_row_t    rows [16];
    pmtid_regs pmtid_regs_inst (.sys_clk, .rst, .sampleValid, .sampleTemp, .sampleOutPower,
        .sampleInPower, .cmdValid, .cmdIn, .rspOut, .rspValid, .nvmLoadValid, .nvmLoadImage,
        .nvmStoreImage, .nvmStoreReq, .revRewritten);
    pmtid_host_model pmtid_host_model_inst (.sys_clk, .cmdIn, .cmdValid, .rspValid, .rspOut);
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic testDone();
        $display("Checks %0d, mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
        nChecks++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic run(input pmtid_cmd_t c, input pmtid_rsp_t e);
        pmtid_host_model_inst.send(c, r, late);
        if (late) begin
            badCount++;
            $display("ERROR answer expected 1 seen 0");
            testDone();
        end else begin
            chk($sformatf("answer %h", c.code), {1'b0, e}, {1'b0, r});
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    initial begin
        rst = 1'b1; sampleValid = '0; nvmLoadValid = 1'b0; nvmLoadImage = '0;
        sampleTemp = 16'hF123; sampleOutPower = 16'h8ABC; sampleInPower = 16'h7FFF;
        badCount = 0; nChecks = 0;
        rows = '{{8'h8D, 1'b0, 2'h0, 16'h0, 16'hF123, 2'h2, 1'b0},
                 {8'h96, 1'b0, 2'h0, 16'h0, 16'h8ABC, 2'h2, 1'b0},
                 {8'h97, 1'b0, 2'h0, 16'h0, 16'h7FFF, 2'h2, 1'b0},
                 {8'h98, 1'b0, 2'h0, 16'h0, 16'h0011, 2'h1, 1'b0},
                 {8'h99, 1'b0, 2'h0, 16'h0, 16'h5A01, 2'h2, 1'b0},
                 {8'h9A, 1'b0, 2'h0, 16'h0, 16'h3C01, 2'h2, 1'b0},
                 {8'h9B, 1'b0, 2'h0, 16'h0, 16'h0101, 2'h2, 1'b0},
                 {8'h99, 1'b1, 2'h2, 16'hAB00, 16'h0, 2'h0, 1'b0},
                 {8'h9A, 1'b1, 2'h1, 16'hC300, 16'h0, 2'h0, 1'b1},
                 {8'h00, 1'b0, 2'h0, 16'h0, 16'h0, 2'h0, 1'b1},
                 {8'h99, 1'b0, 2'h0, 16'h0, 16'hAB01, 2'h2, 1'b0},
                 {8'h9A, 1'b0, 2'h0, 16'h0, 16'h3C01, 2'h2, 1'b0},
                 {8'h9B, 1'b1, 2'h2, 16'h0700, 16'h0, 2'h0, 1'b0},
                 {8'h9B, 1'b0, 2'h0, 16'h0, 16'h0701, 2'h2, 1'b0},
                 {8'h9A, 1'b1, 2'h2, 16'h6600, 16'h0, 2'h0, 1'b0},
                 {8'h9A, 1'b0, 2'h0, 16'h0, 16'h6601, 2'h2, 1'b0}};
        ticks(10);
        rst = 1'b0;
        chk("reset outputs", 20'h0, {rspOut, rspValid});
        chk("reset store", 20'h0, {nvmStoreReq, revRewritten});
        sampleValid = 3'h7;
        ticks(1);
        sampleValid = 3'h0;
        $display("Test reset done");
        foreach (rows[i]) run(rows[i].c, rows[i].e);
        $display("Test table done");
        foreach (rows[i]) if (i < 4) run({rows[i].c.code, 1'b1, 2'h2, 16'h1200}, 19'h1);
        run({8'h99, 1'b1, 2'h2, 16'hCD00}, 19'h0);
        chk("store image", 20'hCD667, nvmStoreImage);
        chk("store pulse", 20'h1, {19'h0, nvmStoreReq});
        chk("rev once", 20'h0, {19'h0, revRewritten});
        run({8'h9B, 1'b1, 2'h2, 16'h0200}, 19'h0);
        chk("rev twice", 20'h1, {19'h0, revRewritten});
        run({8'h9B, 1'b1, 2'h1, 16'h0500}, 19'h1);
        chk("no store", 20'h0, {19'h0, nvmStoreReq});
        $display("Test writes done");
        nvmLoadImage = 20'h12349;
        nvmLoadValid = 1'b1;
        ticks(1);
        nvmLoadValid = 1'b0;
        chk("load no store", 20'h0, {19'h0, nvmStoreReq});
        run({8'h99, 1'b0, 2'h0, 16'h0}, {16'h1201, 2'h2, 1'b0});
        run({8'h9A, 1'b0, 2'h0, 16'h0}, {16'h3401, 2'h2, 1'b0});
        run({8'h9B, 1'b0, 2'h0, 16'h0}, {16'h0901, 2'h2, 1'b0});
        $display("Test load done");
        rst = 1'b1;
        ticks(2);
        rst = 1'b0;
        chk("rev after reset", 20'h0, {19'h0, revRewritten});
        run({8'h99, 1'b0, 2'h0, 16'h0}, {16'h5A01, 2'h2, 1'b0});
        run({8'h8D, 1'b0, 2'h0, 16'h0}, {16'h0000, 2'h2, 1'b0});
        $display("Test second reset done");
        testDone();
    end
endmodule
bind pmtid_regs pmtid_regs_sva pmtid_regs_sva_inst (.sys_clk, .rst, .sampleValid,
    .sampleTemp, .cmdValid, .cmdIn, .rspOut, .rspValid, .nvmStoreImage, .nvmStoreReq);
`default_nettype wire
